// ### design/spsq_device.sv
// Phase sequencer and fault latch of the stepper driver
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "spsq_defines.svh"

module spsq_device #(
   parameter int BLANK_CYC = `SPSQ_BLANK_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Analog sense indications
   input wire logic supply_ok_in,
   input wire logic chop_on_in,
   input wire logic flyback_in,
   input wire logic overcur_in,
   input wire logic overheat_in,
   // Status
   output logic [2:0] position_out,
   output spsq_pkg::spsq_fault_t fault_out,
   // Link
   spsq_link_if.device_mp link
);
   import spsq_pkg::*;

   localparam int NIN = 10;
   localparam int I_STEP = 0;
   localparam int I_DIR = 1;
   localparam int I_EXC = 2;
   localparam int I_EDGE = 3;
   localparam int I_EN = 4;
   localparam int I_RSTN = 5;
   localparam int I_SUP = 6;
   localparam int I_CHOP = 7;
   localparam int I_FLY = 8;
   localparam int I_OC = 9;
   localparam int I_OH = 10;

   logic [NIN:0] raw;
   logic [NIN:0] sync1;
   logic [NIN:0] sync2;
   logic [NIN:0] sync3;
   logic [NIN:0] filt;
   logic [NIN:0] filt_d;
   logic por;
   logic hold_rst;
   logic advance;
   logic [2:0] pos;
   logic [2:0] step_size;
   logic [2:0] next_pos;
   logic [7:0] blank_cnt;
   logic open_armed;
   logic flyback_seen;
   logic driving;
   spsq_fault_t fault;
   spsq_fault_t next_fault;
   logic [3:0] next_phase;
   logic [3:0] phase;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   assign raw = {overheat_in, overcur_in, flyback_in, chop_on_in,
                 supply_ok_in, link.reset_n_in, link.enable,
                 link.edge_select, link.excitation_select,
                 link.direction_in, link.step_clock};

   // A change counts only once stages two and three agree
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         filt <= '0;
         filt_d <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i <= NIN; i++) begin
            if (sync2[i] == sync3[i]) begin
               filt[i] <= sync3[i];
            end
         end
         filt_d <= filt;
      end
   end

   // Supply below threshold holds everything in reset
   assign por = srst_in | ~filt[I_SUP];
   // Reset pin held low keeps the sequencer at its initial state
   assign hold_rst = por | ~filt[I_RSTN];

   // ------------------------------------------------------------
   // Step sequencing
   // ------------------------------------------------------------
   always_comb begin
      advance = filt[I_STEP] & ~filt_d[I_STEP];
      if (!filt[I_EDGE] && !filt[I_STEP] && filt_d[I_STEP]) begin
         advance = 1'b1;
      end
   end

   // From an odd half-step, two-phase mode moves one place to the
   // nearest full-step state rather than restarting
   always_comb begin
      if (filt[I_EXC]) begin
         step_size = 3'h1;
      end else if (pos[0]) begin
         step_size = 3'h1;
      end else begin
         step_size = 3'h2;
      end
      if (filt[I_DIR]) begin
         next_pos = pos - step_size;
      end else begin
         next_pos = pos + step_size;
      end
   end

   // Position freezes while disabled or faulted; it resumes unchanged after a disable, but a fault clears only by the reset that zeroes it
   always_ff @(posedge clk_in) begin
      if (hold_rst) begin
         pos <= 3'h0;
      end else if (advance && filt[I_EN] && fault == SPSQ_FT_NONE) begin
         pos <= next_pos;
      end
   end

   // Bits: A, B, A inverted, B inverted
   always_comb begin
      unique case (pos)
         3'h0: next_phase = 4'h9;
         3'h1: next_phase = 4'h8;
         3'h2: next_phase = 4'hC;
         3'h3: next_phase = 4'h4;
         3'h4: next_phase = 4'h6;
         3'h5: next_phase = 4'h2;
         3'h6: next_phase = 4'h3;
         3'h7: next_phase = 4'h1;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (hold_rst || !filt[I_EN] || fault != SPSQ_FT_NONE) begin
         phase <= 4'h0;
      end else begin
         phase <= next_phase;
      end
   end

   assign driving = |phase;

   // ------------------------------------------------------------
   // Fault detection
   // ------------------------------------------------------------
   // Open check: arm at each off period, look for flyback during it
   always_ff @(posedge clk_in) begin
      if (hold_rst) begin
         open_armed <= 1'b0;
         flyback_seen <= 1'b0;
      end else if (!filt[I_CHOP] && filt_d[I_CHOP]) begin
         open_armed <= driving;
         flyback_seen <= filt[I_FLY];
      end else if (filt[I_CHOP] && !filt_d[I_CHOP]) begin
         open_armed <= 1'b0;
         flyback_seen <= 1'b0;
      end else if (!filt[I_CHOP] && filt[I_FLY]) begin
         flyback_seen <= 1'b1;
      end
   end

   // Blanking counter restarts at each on-period start
   always_ff @(posedge clk_in) begin
      if (hold_rst || !filt[I_CHOP]) begin
         blank_cnt <= 8'h00;
      end else if (blank_cnt < 8'(BLANK_CYC)) begin
         blank_cnt <= blank_cnt + 8'h01;
      end
   end

   // First fault wins and stays; simultaneous ones take the highest
   always_comb begin
      next_fault = fault;
      if (fault == SPSQ_FT_NONE) begin
         if (filt[I_OH]) begin
            next_fault = SPSQ_FT_OVERHEAT;
         end else if (filt[I_CHOP] && filt[I_OC]
                      && blank_cnt == 8'(BLANK_CYC)) begin
            next_fault = SPSQ_FT_OVERCUR;
         end else if (filt[I_CHOP] && !filt_d[I_CHOP]
                      && open_armed && !flyback_seen) begin
            next_fault = SPSQ_FT_OPEN;
         end
      end
      if (hold_rst) begin
         next_fault = SPSQ_FT_NONE;
      end
   end

   always_ff @(posedge clk_in) begin
      fault <= next_fault;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         link.fault_summary_n_drv <= 1'b0;
         link.fault_summary_n_oe <= 1'b0;
         link.fault_type_level <= 2'h0;
         fault_out <= SPSQ_FT_NONE;
      end else begin
         link.fault_summary_n_drv <= 1'b0;
         link.fault_summary_n_oe <= next_fault != SPSQ_FT_NONE;
         link.fault_type_level <= next_fault;
         fault_out <= next_fault;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         position_out <= 3'h0;
      end else begin
         position_out <= pos;
      end
   end

   assign link.phase_a_out = phase[3];
   assign link.phase_b_out = phase[2];
   assign link.phase_a_inv_out = phase[1];
   assign link.phase_b_inv_out = phase[0];

endmodule

`default_nettype wire

// ### design/spsq_defines.svh
// Timing counts and register map of the stepper sequencer link
`ifndef SPSQ_DEFINES_SVH
`define SPSQ_DEFINES_SVH

`define SPSQ_CLK_PERIOD_NS 100
// Least times in ns, rounded up to cycles
`define SPSQ_T_PULSE_NS 10000
`define SPSQ_T_RST_WAIT_NS 10000
`define SPSQ_T_DIR_SETUP_NS 6250
`define SPSQ_T_MODE_SETUP_NS 5000
`define SPSQ_T_BLANK_NS 5500
`define SPSQ_CYC(ns) (((ns) + `SPSQ_CLK_PERIOD_NS - 1) / `SPSQ_CLK_PERIOD_NS)
`define SPSQ_PULSE_CYC `SPSQ_CYC(`SPSQ_T_PULSE_NS)
`define SPSQ_RST_WAIT_CYC `SPSQ_CYC(`SPSQ_T_RST_WAIT_NS)
`define SPSQ_DIR_SETUP_CYC `SPSQ_CYC(`SPSQ_T_DIR_SETUP_NS)
`define SPSQ_MODE_SETUP_CYC `SPSQ_CYC(`SPSQ_T_MODE_SETUP_NS)
`define SPSQ_BLANK_CYC `SPSQ_CYC(`SPSQ_T_BLANK_NS)

// Host register offsets (APB byte addresses)
`define SPSQ_REG_CTRL 8'h00
`define SPSQ_REG_STEP 8'h04
`define SPSQ_REG_RESET 8'h08
`define SPSQ_REG_STATUS 8'h0C
// Control register fields
`define SPSQ_CTRL_ENABLE 0
`define SPSQ_CTRL_DIR 1
`define SPSQ_CTRL_EXC 2
`define SPSQ_CTRL_EDGE 3
`define SPSQ_CTRL_RESET 4'h0

`endif

// ### design/spsq_pkg.sv
// Types shared by both ends of the stepper sequencer link
package spsq_pkg;

   typedef enum logic [1:0] {
      SPSQ_FT_NONE = 2'h0,
      SPSQ_FT_OPEN = 2'h1,
      SPSQ_FT_OVERCUR = 2'h2,
      SPSQ_FT_OVERHEAT = 2'h3
   } spsq_fault_t;

   typedef enum logic [5:0] {
      SPSQ_H_IDLE = 6'h01,
      SPSQ_H_SETUP = 6'h02,
      SPSQ_H_HIGH = 6'h04,
      SPSQ_H_LOW = 6'h08,
      SPSQ_H_RSTLO = 6'h10,
      SPSQ_H_RSTWAIT = 6'h20
   } spsq_host_state_t;

endpackage

// ### design/spsq_link_if.sv
// Pin-level link between the step controller and the sequencer
`timescale 1ns/100ps
`default_nettype none

interface spsq_link_if;
   logic step_clock;
   logic direction_in;
   logic excitation_select;
   logic edge_select;
   logic enable;
   logic reset_n_in;
   logic phase_a_out;
   logic phase_b_out;
   logic phase_a_inv_out;
   logic phase_b_inv_out;
   logic fault_summary_n_drv;
   logic fault_summary_n_oe;
   logic [1:0] fault_type_level;
   logic fault_summary_n;

   // Open drain with pull-up
   assign fault_summary_n = fault_summary_n_oe ? fault_summary_n_drv : 1'b1;

   modport device_mp (
      input step_clock, direction_in, excitation_select, edge_select,
      input enable, reset_n_in,
      output phase_a_out, phase_b_out, phase_a_inv_out, phase_b_inv_out,
      output fault_summary_n_drv, fault_summary_n_oe, fault_type_level
   );

   modport host_mp (
      output step_clock, direction_in, excitation_select, edge_select,
      output enable, reset_n_in,
      input phase_a_out, phase_b_out, phase_a_inv_out, phase_b_inv_out,
      input fault_summary_n, fault_type_level
   );
endinterface

`default_nettype wire

// ### design/spsq_host.sv
// Step controller end: APB registers driving the sequencer link
`timescale 1ns/100ps
`default_nettype none
`include "spsq_defines.svh"

module spsq_host (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Logic supply good, same clock domain
   input wire logic supply_ok_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Link
   spsq_link_if.host_mp link
);
   import spsq_pkg::*;

   logic [3:0] ctrl;
   logic [15:0] steps_left;
   logic rst_pend;
   logic [2:0] s1;
   logic [2:0] s2;
   logic [2:0] s3;
   logic [2:0] fin;
   logic [7:0] cnt;
   logic busy;
   logic wr;
   logic en_applied;
   spsq_host_state_t state;

   assign busy = state != SPSQ_H_IDLE || steps_left != 16'h0000 || rst_pend;
   assign wr = psel_in & penable_in & pwrite_in & pready_out;

   // ------------------------------------------------------------
   // APB slave, one wait-free access phase
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end else begin
         pready_out <= psel_in & ~penable_in;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         if (psel_in && !penable_in) begin
            unique case (paddr_in)
               `SPSQ_REG_CTRL: prdata_out <= {28'h0, ctrl};
               `SPSQ_REG_STEP: prdata_out <= {16'h0, steps_left};
               `SPSQ_REG_RESET: prdata_out <= 32'h0000_0000;
               `SPSQ_REG_STATUS: prdata_out <= {28'h0, fin[2:1], ~fin[0], busy};
               default: pslverr_out <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ctrl <= `SPSQ_CTRL_RESET;
      end else if (wr && paddr_in == `SPSQ_REG_CTRL) begin
         ctrl <= pwdata_in[3:0];
      end
   end

   // A write while busy is ignored
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         steps_left <= 16'h0000;
      end else if (wr && paddr_in == `SPSQ_REG_STEP && !busy) begin
         steps_left <= pwdata_in[15:0];
      end else if (state == SPSQ_H_LOW && cnt == 8'(`SPSQ_PULSE_CYC - 1)) begin
         steps_left <= steps_left - 16'h0001;
      end
   end

   // Request set wins over its consumption in the same cycle
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rst_pend <= 1'b0;
      end else if (wr && paddr_in == `SPSQ_REG_RESET) begin
         rst_pend <= 1'b1;
      end else if (state == SPSQ_H_IDLE) begin
         rst_pend <= 1'b0;
      end
   end

   // Fault pins come from the other party: three-stage synchroniser
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s1 <= 3'h1;
         s2 <= 3'h1;
         s3 <= 3'h1;
         fin <= 3'h1;
      end else begin
         s1 <= {link.fault_type_level, link.fault_summary_n};
         s2 <= s1;
         s3 <= s2;
         for (int i = 0; i < 3; i++) begin
            if (s2[i] == s3[i]) begin
               fin[i] <= s3[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Pin sequencer
   // ------------------------------------------------------------
   // Mode and direction change together only while the clock is idle,
   // then wait out the longer setup before the next rising edge
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state <= SPSQ_H_RSTLO;
         cnt <= 8'h00;
         link.step_clock <= 1'b0;
         link.reset_n_in <= 1'b0;
         link.direction_in <= 1'b0;
         link.excitation_select <= 1'b0;
         link.edge_select <= 1'b0;
         en_applied <= 1'b0;
      end else begin
         cnt <= cnt + 8'h01;
         unique case (state)
            SPSQ_H_IDLE: begin
               cnt <= 8'h00;
               if (rst_pend) begin
                  link.reset_n_in <= 1'b0;
                  state <= SPSQ_H_RSTLO;
               end else if ({ctrl[`SPSQ_CTRL_EDGE], ctrl[`SPSQ_CTRL_EXC],
                             ctrl[`SPSQ_CTRL_DIR], ctrl[`SPSQ_CTRL_ENABLE]}
                            != {link.edge_select, link.excitation_select,
                                link.direction_in, en_applied}) begin
                  link.edge_select <= ctrl[`SPSQ_CTRL_EDGE];
                  link.excitation_select <= ctrl[`SPSQ_CTRL_EXC];
                  link.direction_in <= ctrl[`SPSQ_CTRL_DIR];
                  en_applied <= ctrl[`SPSQ_CTRL_ENABLE];
                  state <= SPSQ_H_SETUP;
               end else if (steps_left != 16'h0000) begin
                  link.step_clock <= 1'b1;
                  state <= SPSQ_H_HIGH;
               end
            end
            SPSQ_H_SETUP: begin
               if (cnt == 8'(`SPSQ_DIR_SETUP_CYC - 1)) begin
                  state <= SPSQ_H_IDLE;
               end
            end
            SPSQ_H_HIGH: begin
               if (cnt == 8'(`SPSQ_PULSE_CYC - 1)) begin
                  link.step_clock <= 1'b0;
                  cnt <= 8'h00;
                  state <= SPSQ_H_LOW;
               end
            end
            SPSQ_H_LOW: begin
               if (cnt == 8'(`SPSQ_PULSE_CYC - 1)) begin
                  state <= SPSQ_H_IDLE;
               end
            end
            SPSQ_H_RSTLO: begin
               if (cnt == 8'(`SPSQ_PULSE_CYC - 1)) begin
                  link.reset_n_in <= 1'b1;
                  cnt <= 8'h00;
                  state <= SPSQ_H_RSTWAIT;
               end
            end
            SPSQ_H_RSTWAIT: begin
               if (cnt == 8'(`SPSQ_RST_WAIT_CYC - 1)) begin
                  state <= SPSQ_H_IDLE;
               end
            end
         endcase
      end
   end

   // Supply loss drops enable one clock later, outside the sequencer
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         link.enable <= 1'b0;
      end else begin
         link.enable <= en_applied & supply_ok_in;
      end
   end

endmodule

`default_nettype wire

// ### dv/spsq_sva.sv
// Concurrent checks on the stepper sequencer link
`timescale 1ns/100ps
`default_nettype none

module spsq_sva (
   // Clock, reset and supply
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic supply_ok_in,
   // Link
   input wire logic step_clock,
   input wire logic edge_select,
   input wire logic enable,
   input wire logic reset_n_in,
   input wire logic phase_a_out,
   input wire logic phase_b_out,
   input wire logic phase_a_inv_out,
   input wire logic phase_b_inv_out,
   input wire logic fault_summary_n_drv,
   input wire logic fault_summary_n_oe,
   input wire logic [1:0] fault_type_level,
   input wire logic fault_summary_n
);
   logic [3:0] ph;
   logic run;
   assign ph = {phase_a_out, phase_b_out, phase_a_inv_out, phase_b_inv_out};
   // Steps only count while nothing holds the sequencer back
   assign run = enable && reset_n_in && supply_ok_in && fault_type_level == 2'h0;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // ------------
   // Sequences
   // ------------
   sequence rise_s; $rose(step_clock) && run; endsequence
   sequence fall_s; $fell(step_clock) && run; endsequence
   // Long enough for any earlier clear request to have passed the synchronisers
   sequence up_s; (reset_n_in && supply_ok_in)[*6]; endsequence
   // ------------
   // Assertions
   // ------------
   a_step_moves: assert property (rise_s |-> ##[2:10] $changed(ph))
      else $error("phases still after a rising step edge");
   a_both_edges: assert property ((fall_s ##0 !edge_select) |-> ##[2:10] $changed(ph))
      else $error("phases still after a falling edge in both-edge mode");
   a_rise_only: assert property ((fall_s ##0 edge_select) |-> $stable(ph)[*8])
      else $error("phases moved on a falling edge in rising-only mode");
   a_enable_off: assert property ((!enable)[*8] |-> ph == 4'h0)
      else $error("phases driven while disabled");
   a_fault_off: assert property ((!fault_summary_n)[*3] |-> ph == 4'h0)
      else $error("phases driven while a fault is latched");
   a_summary_type: assert property (fault_summary_n == (fault_type_level == 2'h0))
      else $error("summary fault line disagrees with fault type");
   a_open_drain: assert property (fault_summary_n_oe |-> !fault_summary_n_drv)
      else $error("open drain output driven high");
   a_fault_latched: assert property ((up_s ##0 fault_type_level != 2'h0) |=> $stable(fault_type_level))
      else $error("latched fault changed without a clear");
   a_reset_clears: assert property ((!reset_n_in)[*8] |-> fault_type_level == 2'h0 && fault_summary_n)
      else $error("fault not cleared by reset input");
   a_reset_start: assert property (($rose(reset_n_in) && enable && supply_ok_in) |-> ##[1:8] ph == 4'h9)
      else $error("initial phases not A with B inverted");
   a_legal_pattern: assert property (!(phase_a_out && phase_a_inv_out) && !(phase_b_out && phase_b_inv_out))
      else $error("both halves of one phase energized");
endmodule

`default_nettype wire

// ### dv/tb.sv
// Self-checking bench joining controller and sequencer ends
`timescale 1ns/100ps
`default_nettype none
`include "spsq_defines.svh"

module tb;
   import spsq_pkg::*;
   // ------------
   // Signals
   // ------------
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic supply_ok_in = 1'b1;
   // Chopping starts in its on phase so no stray off period is judged early
   logic chop_on_in = 1'b1;
   logic flyback_in = 1'b0;
   logic overcur_in = 1'b0;
   logic overheat_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h00000000;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic [2:0] position_out;
   spsq_fault_t fault_out;
   logic [3:0] ph;
   logic [3:0] ph_kept;
   logic [31:0] rd;
   logic err;
   int errors = 0;
   int total_checks = 0;
   int pos = 0;
   // Phases are expected live unless a scenario has disabled or faulted the driver
   logic on_exp = 1'b1;

   spsq_link_if link_i ();
   assign ph = {link_i.phase_a_out, link_i.phase_b_out, link_i.phase_a_inv_out,
      link_i.phase_b_inv_out};
   spsq_device #(.BLANK_CYC(4)) spsq_device_i (.clk_in(clk_in), .srst_in(srst_in),
      .supply_ok_in(supply_ok_in), .chop_on_in(chop_on_in), .flyback_in(flyback_in),
      .overcur_in(overcur_in), .overheat_in(overheat_in), .position_out(position_out),
      .fault_out(fault_out), .link(link_i));
   spsq_host spsq_host_i (.clk_in(clk_in), .srst_in(srst_in), .supply_ok_in(supply_ok_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .link(link_i));
   spsq_sva spsq_sva_i (.clk_in(clk_in), .srst_in(srst_in), .supply_ok_in(supply_ok_in),
      .step_clock(link_i.step_clock), .edge_select(link_i.edge_select),
      .enable(link_i.enable), .reset_n_in(link_i.reset_n_in),
      .phase_a_out(link_i.phase_a_out), .phase_b_out(link_i.phase_b_out),
      .phase_a_inv_out(link_i.phase_a_inv_out), .phase_b_inv_out(link_i.phase_b_inv_out),
      .fault_summary_n_drv(link_i.fault_summary_n_drv),
      .fault_summary_n_oe(link_i.fault_summary_n_oe),
      .fault_type_level(link_i.fault_type_level), .fault_summary_n(link_i.fault_summary_n));

   always #50 clk_in = ~clk_in;

   // ------------
   // Helpers
   // ------------
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic timeout(input string name);
      errors++;
      $display("Error %s wait ran out", name);
      finish_test();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n;
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= addr;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (pready_out !== 1'b1) timeout("pready");
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // A control change costs a setup wait; a step count written meanwhile would be dropped
   task automatic ctrl(input logic [3:0] c);
      apb(1'b1, `SPSQ_REG_CTRL, {28'h0000000, c});
      wait_idle();
   endtask

   // Busy covers the pulse train; a few edges more let the phases land
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, `SPSQ_REG_STATUS, 32'h00000000);
         n++;
      end while (rd[0] !== 1'b0 && n < 600);
      if (rd[0] !== 1'b0) timeout("idle");
      cyc(8);
   endtask

   // Excitation from position 0 forward; bits A, B, A inverted, B inverted
   function automatic logic [3:0] ph_of(input int p);
      case (p & 7)
         0: return 4'h9;
         1: return 4'h8;
         2: return 4'hC;
         3: return 4'h4;
         4: return 4'h6;
         5: return 4'h2;
         6: return 4'h3;
         default: return 4'h1;
      endcase
   endfunction

   task automatic step(input logic [15:0] n, input int delta);
      apb(1'b1, `SPSQ_REG_STEP, {16'h0000, n});
      wait_idle();
      pos = (pos + delta) & 7;
      chk("position", 32'(pos), {29'h0, position_out});
      chk("phases", {28'h0, on_exp ? ph_of(pos) : 4'h0}, {28'h0, ph});
   endtask

   task automatic flt(input logic [1:0] code);
      chk("fault level", {30'h0, code}, {30'h0, link_i.fault_type_level});
      chk("fault summary", {31'h0, code == 2'h0}, {31'h0, link_i.fault_summary_n});
      chk("fault out", {30'h0, code}, {30'h0, fault_out});
   endtask

   // Ends on the rising edge of the next on period
   task automatic chop(input logic fly);
      chop_on_in <= 1'b0;
      flyback_in <= fly;
      cyc(10);
      chop_on_in <= 1'b1;
      flyback_in <= 1'b0;
   endtask

   // ------------
   // Scenarios
   // ------------
   task automatic t_start();
      apb(1'b0, 8'h10, 32'h00000000);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      ctrl(4'hD);
      apb(1'b0, `SPSQ_REG_CTRL, 32'h00000000);
      chk("ctrl", 32'hD, rd);
      apb(1'b1, `SPSQ_REG_RESET, 32'h00000000);
      wait_idle();
      chk("position", 32'h0, {29'h0, position_out});
      chk("phases", 32'h9, {28'h0, ph});
   endtask

   task automatic t_seq();
      ctrl(4'hF);
      step(16'h1, -1);
      ctrl(4'hD);
      step(16'h1, 1);
      ctrl(4'h9);
      step(16'h3, 6);
      ctrl(4'hB);
      step(16'h1, -2);
      ctrl(4'hF);
      step(16'h1, -1);
      ctrl(4'h5);
      step(16'h1, 2);
      ctrl(4'h9);
      step(16'h1, 1);
   endtask

   task automatic t_enable();
      ctrl(4'hD);
      ph_kept = ph;
      ctrl(4'hC);
      cyc(10);
      chk("phases", 32'h0, {28'h0, ph});
      on_exp = 1'b0;
      step(16'h1, 0);
      ctrl(4'hD);
      on_exp = 1'b1;
      cyc(10);
      chk("phases", {28'h0, ph_kept}, {28'h0, ph});
      step(16'h1, 1);
   endtask

   task automatic t_faults();
      logic [1:0] code;
      for (int k = 1; k <= 3; k++) begin
         code = 2'(k);
         if (k == 1) begin
            chop(1'b1);
            cyc(12);
            flt(2'h0);
            chop(1'b0);
         end else if (k == 2) begin
            chop(1'b1);
            overcur_in <= 1'b1;
            cyc(2);
            overcur_in <= 1'b0;
            cyc(12);
            flt(2'h0);
            overcur_in <= 1'b1;
         end else begin
            overheat_in <= 1'b1;
         end
         cyc(12);
         overcur_in <= 1'b0;
         overheat_in <= 1'b0;
         flt(code);
         chk("phases", 32'h0, {28'h0, ph});
         apb(1'b0, `SPSQ_REG_STATUS, 32'h00000000);
         chk("status", {29'h0, code, 1'b1}, {29'h0, rd[3:1]});
         on_exp = 1'b0;
         step(16'h1, 0);
         if (k < 3) begin
            apb(1'b1, `SPSQ_REG_RESET, 32'h00000000);
            wait_idle();
         end else begin
            supply_ok_in <= 1'b0;
            cyc(10);
            supply_ok_in <= 1'b1;
            cyc(12);
         end
         pos = 0;
         on_exp = 1'b1;
         flt(2'h0);
         chk("position", 32'h0, {29'h0, position_out});
      end
   endtask

   initial begin
      cyc(4);
      srst_in <= 1'b0;
      t_start();
      t_seq();
      t_enable();
      t_faults();
      finish_test();
   end
endmodule

`default_nettype wire
